// ---- hdl/dps_pkg.sv ----
// shared constants, opcodes and register map of the dual pot front end
package dps_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WIPER_LAT_US = 10;
    localparam int WIPER_SETTLE_US = 10;
    localparam int PU_WAIT_MS = 1;
    localparam int NV_WRITE_MS = 5;
    // longest times round down, least times round up
    localparam int WIPER_LAT_CYC = WIPER_LAT_US * 1000 / CLK_PERIOD_NS;
    localparam int WIPER_SETTLE_CYC = WIPER_SETTLE_US * 1000 / CLK_PERIOD_NS;
    localparam int PU_WAIT_CYC =
        (PU_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int LAT_W = $clog2(WIPER_LAT_CYC + WIPER_SETTLE_CYC + 1);
    localparam int SCK_HALF_CYC = 8;
    localparam int DIV_W = 4;
    localparam int POTS = 2;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] SHORT_BITS = 5'h10;

    // device type code: value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'h9;
    localparam logic [7:0] SETTING_RST = 8'h80;

    localparam logic [3:0] OP_RD_WPOS = 4'h9;
    localparam logic [3:0] OP_WR_WPOS = 4'ha;
    localparam logic [3:0] OP_RD_SET = 4'hb;
    localparam logic [3:0] OP_WR_SET = 4'hc;
    localparam logic [3:0] OP_SET_TO_WPOS = 4'hd;
    localparam logic [3:0] OP_WPOS_TO_SET = 4'he;
    localparam logic [3:0] OP_GSET_TO_WPOS = 4'h1;
    localparam logic [3:0] OP_GWPOS_TO_SET = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;
    localparam logic [3:0] OP_RD_STATUS = 4'h5;

    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_CLR = 8'h0c;
    localparam logic [7:0] REG_IRQ_EN = 8'h10;
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_INS_LSB = 8;
    localparam int CMD_OP_LSB = 12;
    localparam int CMD_BSEL_LSB = 16;
    localparam int CMD_W = 18;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PURDY_BIT = 1;
    localparam int STAT_RX_LSB = 8;
    localparam int EV_DONE_BIT = 0;
    localparam int EV_REFUSED_BIT = 1;
    localparam logic [1:0] IRQ_EN_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef logic [7:0] dps_byte_t;

    // transfers carry no data byte
    function automatic logic [4:0] dps_cmd_bits(input logic [3:0] op);
        if (op == OP_SET_TO_WPOS || op == OP_WPOS_TO_SET ||
            op == OP_GSET_TO_WPOS || op == OP_GWPOS_TO_SET) begin
            return SHORT_BITS;
        end
        return FRAME_BITS;
    endfunction : dps_cmd_bits

    function automatic logic dps_mapped(input logic [7:0] a);
        return a == REG_CMD || a == REG_STATUS || a == REG_IRQ_STAT ||
            a == REG_IRQ_CLR || a == REG_IRQ_EN;
    endfunction : dps_mapped
endpackage : dps_pkg

// ---- hdl/dps_spi_if.sv ----
// serial link joining the host end and the device end
`timescale 1ns/10ps
interface dps_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // undriven line floats high through a pull-up
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (
        input cs_n,
        input sck,
        input mosi,
        output miso,
        output miso_oe
    );
    modport host (
        output cs_n,
        output sck,
        output mosi,
        input miso_line
    );
endinterface : dps_spi_if

// ---- hdl/dps_pot_dev.sv ----
// device end: serial command decoder, wiper and setting storage
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
// What this block and the host end do
// [RULE_01] first byte after select is address
// [RULE_02] upper address nibble must equal type code
// [RULE_03] low address bits must match board pins
// [RULE_04] host sends middle address bits as zero
// [RULE_05] second byte is the instruction byte
// [RULE_06] instruction upper nibble is the opcode
// [RULE_07] next two bits pick setting slot
// [RULE_08] low two bits pick the wiper
// [RULE_09] wiper follows register within 10 us
// [RULE_10] wiper settles within 10 us after power
// [RULE_11] host waits 1 ms before any command
// [RULE_12] data sampled on serial clock rise
// [RULE_13] setting save starts at deselect, max 5 ms
// [RULE_14] status read shows write pending bit
// [RULE_15] power-up loads wipers from slot zero
// [RULE_16] mismatched device ignores frame, stays off line
module dps_pot_dev #(
    parameter int NV_CYC = dps_pkg::NV_WRITE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] board_select_bits_i,
    dps_spi_if.dev spi,
    output logic [dps_pkg::POTS-1:0][7:0] wiper_tap_o,
    output logic nv_write_pending_o
);
    import dps_pkg::*;

    localparam int NVW = $clog2(NV_CYC + 1);

    logic [2:0] cs_q;
    logic [2:0] sck_q;
    logic [1:0] mosi_q;
    logic [1:0] bsel_q0;
    logic [1:0] bsel_q1;
    logic sel;
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    logic [4:0] bit_cnt;
    dps_byte_t rx;
    dps_byte_t rx_next;
    logic byte_done;
    logic [1:0] byte_idx;
    logic matched;
    logic [3:0] opcode_field;
    logic [1:0] slot_idx;
    logic [1:0] wiper_idx;
    logic [3:0] op_i;
    logic instr_done;
    logic data_done;
    logic step_rise;
    logic rd_op;
    dps_byte_t rd_val;
    dps_byte_t tx;
    logic miso_q;
    logic oe_q;
    logic loaded;
    logic commit;
    logic [NVW-1:0] nv_cnt;
    dps_byte_t wpos [POTS];
    logic [3:0][7:0] setting [POTS];
    dps_byte_t tap [POTS];
    logic pend_v [POTS];

    // pins pass two flops; edges come from the second and third
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_q <= 3'h7;
            sck_q <= 3'h0;
            mosi_q <= 2'h0;
            bsel_q0 <= 2'h0;
            bsel_q1 <= 2'h0;
        end else begin
            cs_q <= {cs_q[1:0], spi.cs_n};
            sck_q <= {sck_q[1:0], spi.sck};
            mosi_q <= {mosi_q[0], spi.mosi};
            bsel_q0 <= board_select_bits_i;
            bsel_q1 <= bsel_q0;
        end
    end

    assign sel = !cs_q[1];
    assign sck_rise = sel && sck_q[1] && !sck_q[2]; // see [RULE_12]
    assign sck_fall = sel && !sck_q[1] && sck_q[2];
    assign frame_end = cs_q[1] && !cs_q[2];
    assign rx_next = {rx[6:0], mosi_q[1]};
    assign byte_idx = bit_cnt[4:3];
    assign byte_done = sck_rise && bit_cnt[2:0] == 3'h7;
    assign op_i = rx_next[7:4];
    assign instr_done = matched && byte_done && byte_idx == 2'h1;
    assign data_done = matched && byte_done && byte_idx == 2'h2;
    assign step_rise = matched && sck_rise && byte_idx[1] &&
        opcode_field == OP_STEP;
    assign rd_op = opcode_field == OP_RD_WPOS ||
        opcode_field == OP_RD_SET || opcode_field == OP_RD_STATUS;

    // frame parser; the count stops at a full frame so no late byte ends
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_cnt <= 5'h0;
            rx <= 8'h0;
            matched <= 1'b0;
            opcode_field <= 4'h0;
            slot_idx <= 2'h0;
            wiper_idx <= 2'h0;
        end else if (!sel) begin
            bit_cnt <= 5'h0;
            matched <= 1'b0; // see [RULE_16]
        end else if (sck_rise) begin
            rx <= rx_next;
            if (bit_cnt != FRAME_BITS) begin
                bit_cnt <= bit_cnt + 5'h1;
            end
            if (byte_done && byte_idx == 2'h0) begin // see [RULE_01]
                matched <= rx_next[7:4] == DEV_TYPE && // see [RULE_02]
                    rx_next[1:0] == bsel_q1; // see [RULE_03]
            end
            if (instr_done) begin // see [RULE_05]
                opcode_field <= op_i; // see [RULE_06]
                slot_idx <= rx_next[3:2]; // see [RULE_07]
                wiper_idx <= rx_next[1:0]; // see [RULE_08]
            end
        end
    end

    always_comb begin
        case (op_i)
            OP_RD_WPOS: rd_val = wpos[rx_next[0]];
            OP_RD_SET: rd_val = setting[rx_next[0]][rx_next[3:2]];
            OP_RD_STATUS: rd_val = {7'h0, nv_write_pending_o}; // see [RULE_14]
            default: rd_val = 8'h0;
        endcase
    end

    // reply shifts out on falling edges, line released while deselected
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx <= 8'h0;
            miso_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (!sel) begin
            oe_q <= 1'b0;
        end else if (instr_done) begin
            tx <= rd_val;
        end else if (sck_fall && matched && byte_idx == 2'h2 && rd_op) begin
            miso_q <= tx[7];
            tx <= {tx[6:0], 1'b0};
            oe_q <= 1'b1; // see [RULE_16]
        end
    end

    assign spi.miso = miso_q;
    assign spi.miso_oe = oe_q;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loaded <= 1'b0;
        end else begin
            loaded <= 1'b1;
        end
    end

    // save begins only when the frame closes
    assign commit = frame_end && (pend_v[0] || pend_v[1]);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            nv_cnt <= '0;
            nv_write_pending_o <= 1'b0;
        end else if (commit) begin
            nv_cnt <= NVW'(NV_CYC - 1); // see [RULE_13]
            nv_write_pending_o <= 1'b1;
        end else if (nv_cnt != '0) begin
            nv_cnt <= nv_cnt - 1'b1;
        end else begin
            nv_write_pending_o <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < POTS; g++) begin : g_pot
            logic hit_i;
            logic hit_d;
            dps_byte_t next_wpos;
            logic [1:0] pend_slot;
            dps_byte_t pend_val;
            logic lat_run;
            logic [LAT_W-1:0] lat_cnt;

            // only two pots, so the low wiper index bit decides
            assign hit_i = rx_next[0] == 1'(g); // see [RULE_08]
            assign hit_d = wiper_idx[0] == 1'(g);

            always_comb begin
                next_wpos = wpos[g];
                if (!loaded) begin
                    next_wpos = setting[g][0]; // see [RULE_15]
                end else if (instr_done && (op_i == OP_GSET_TO_WPOS ||
                    (op_i == OP_SET_TO_WPOS && hit_i))) begin
                    next_wpos = setting[g][rx_next[3:2]]; // see [RULE_07]
                end else if (data_done && hit_d &&
                    opcode_field == OP_WR_WPOS) begin
                    next_wpos = rx_next;
                end else if (step_rise && hit_d) begin
                    if (mosi_q[1] && wpos[g] != 8'hff) begin
                        next_wpos = wpos[g] + 8'h1;
                    end else if (!mosi_q[1] && wpos[g] != 8'h00) begin
                        next_wpos = wpos[g] - 8'h1;
                    end
                end
            end

            // a busy store refuses new saves rather than queue them
            always_ff @(posedge sys_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pend_v[g] <= 1'b0;
                    pend_slot <= 2'h0;
                    pend_val <= 8'h0;
                end else if (frame_end) begin
                    pend_v[g] <= 1'b0;
                end else if (!nv_write_pending_o && instr_done &&
                    (op_i == OP_GWPOS_TO_SET ||
                    (op_i == OP_WPOS_TO_SET && hit_i))) begin
                    pend_v[g] <= 1'b1;
                    pend_slot <= rx_next[3:2];
                    pend_val <= wpos[g];
                end else if (!nv_write_pending_o && data_done && hit_d &&
                    opcode_field == OP_WR_SET) begin
                    pend_v[g] <= 1'b1;
                    pend_slot <= slot_idx;
                    pend_val <= rx_next;
                end
            end

            // stored settings reset to a constant in place of real memory
            always_ff @(posedge sys_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    wpos[g] <= SETTING_RST;
                    setting[g] <= {4{SETTING_RST}};
                end else begin
                    wpos[g] <= next_wpos;
                    if (frame_end && pend_v[g]) begin
                        setting[g][pend_slot] <= pend_val; // see [RULE_13]
                    end
                end
            end

            // timer is not restarted, so a stream of steps still lands
            always_ff @(posedge sys_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    lat_run <= 1'b1;
                    lat_cnt <= LAT_W'(WIPER_SETTLE_CYC - 1); // see [RULE_10]
                    tap[g] <= SETTING_RST;
                end else if (lat_run && lat_cnt == '0) begin
                    tap[g] <= next_wpos; // see [RULE_09]
                    lat_run <= 1'b0;
                end else if (lat_run) begin
                    lat_cnt <= lat_cnt - 1'b1;
                end else if (next_wpos != wpos[g]) begin
                    lat_run <= 1'b1;
                    lat_cnt <= LAT_W'(WIPER_LAT_CYC - 1); // see [RULE_09]
                end
            end

            assign wiper_tap_o[g] = tap[g];
        end
    endgenerate
endmodule : dps_pot_dev

// ---- hdl/dps_pot_host.sv ----
// host end: AXI4-Lite command registers driving the serial link
`timescale 1ns/10ps
module dps_pot_host #(
    parameter int PU_CYC = dps_pkg::PU_WAIT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [dps_pkg::AXI_AW-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [dps_pkg::AXI_AW-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic irq_o,
    dps_spi_if.host spi
);
    import dps_pkg::*;

    localparam int PUW = $clog2(PU_CYC + 1);

    typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_HOLD, ST_REST}
        dps_host_st_e;

    dps_host_st_e st;
    logic wr_rdy;
    logic rd_rdy;
    logic wr_take;
    logic rd_take;
    logic start;
    logic ev_done;
    logic ev_refused;
    logic pu_ready;
    logic [PUW-1:0] pu_cnt;
    logic [CMD_W-1:0] cmd_last;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [1:0] clr;
    logic [31:0] rd_val;
    logic [DIV_W-1:0] div;
    logic tick;
    logic [23:0] tx;
    logic [4:0] bits;
    dps_byte_t rx;
    dps_byte_t rx_byte;
    logic [1:0] miso_q;
    logic cs_n_q;
    logic sck_q;
    logic mosi_q;

    assign awready_o = wr_rdy;
    assign wready_o = wr_rdy;
    assign arready_o = rd_rdy;
    assign wr_take = wr_rdy && awvalid_i && wvalid_i;
    assign rd_take = rd_rdy && arvalid_i;
    assign start = wr_take && awaddr_i == REG_CMD &&
        st == ST_IDLE && pu_ready; // see [RULE_11]
    assign ev_refused = wr_take && awaddr_i == REG_CMD && !start;
    assign clr = (wr_take && awaddr_i == REG_IRQ_CLR && wstrb_i[0]) ?
        wdata_i[1:0] : 2'h0;
    assign tick = div == '0;

    // address and data are taken together in one cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_rdy <= 1'b0;
            bvalid_o <= 1'b0;
            bresp_o <= RESP_OKAY;
        end else begin
            wr_rdy <= !wr_rdy && !bvalid_o && awvalid_i && wvalid_i;
            if (wr_take) begin
                bvalid_o <= 1'b1;
                bresp_o <= dps_mapped(awaddr_i) ? RESP_OKAY : RESP_DECERR;
            end else if (bready_i) begin
                bvalid_o <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_val = 32'h0;
        case (araddr_i)
            REG_CMD: rd_val[CMD_W-1:0] = cmd_last;
            REG_STATUS: begin
                rd_val[STAT_BUSY_BIT] = st != ST_IDLE;
                rd_val[STAT_PURDY_BIT] = pu_ready;
                rd_val[STAT_RX_LSB +: 8] = rx_byte;
            end
            REG_IRQ_STAT: rd_val[1:0] = irq_stat;
            REG_IRQ_EN: rd_val[1:0] = irq_en;
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_rdy <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0;
            rresp_o <= RESP_OKAY;
        end else begin
            rd_rdy <= !rd_rdy && !rvalid_o && arvalid_i;
            if (rd_take) begin
                rvalid_o <= 1'b1;
                rdata_o <= rd_val;
                rresp_o <= dps_mapped(araddr_i) ? RESP_OKAY : RESP_DECERR;
            end else if (rready_i) begin
                rvalid_o <= 1'b0;
            end
        end
    end

    // events win over a clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat <= 2'h0;
            irq_en <= IRQ_EN_RST;
            irq_o <= 1'b0;
        end else begin
            if (wr_take && awaddr_i == REG_IRQ_EN && wstrb_i[0]) begin
                irq_en <= wdata_i[1:0];
            end
            irq_stat[EV_DONE_BIT] <= ev_done ||
                (irq_stat[EV_DONE_BIT] && !clr[EV_DONE_BIT]);
            irq_stat[EV_REFUSED_BIT] <= ev_refused ||
                (irq_stat[EV_REFUSED_BIT] && !clr[EV_REFUSED_BIT]);
            irq_o <= |(irq_stat & irq_en);
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pu_cnt <= '0;
            pu_ready <= 1'b0;
        end else if (!pu_ready) begin
            pu_cnt <= pu_cnt + 1'b1;
            pu_ready <= pu_cnt == PUW'(PU_CYC - 1); // see [RULE_11]
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            miso_q <= 2'h3;
            div <= DIV_W'(SCK_HALF_CYC - 1);
        end else begin
            miso_q <= {miso_q[0], spi.miso_line};
            div <= (st == ST_IDLE || tick) ?
                DIV_W'(SCK_HALF_CYC - 1) : div - 1'b1;
        end
    end

    // clock made by division; data changes with the falling edge
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= ST_IDLE;
            tx <= 24'h0;
            bits <= 5'h0;
            rx <= 8'h0;
            rx_byte <= 8'h0;
            cmd_last <= '0;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
            ev_done <= 1'b0;
        end else begin
            ev_done <= 1'b0;
            unique case (st)
                ST_IDLE: if (start) begin
                    cmd_last <= wdata_i[CMD_W-1:0];
                    tx <= {DEV_TYPE, 2'h0, // see [RULE_01] [RULE_02] [RULE_04]
                        wdata_i[CMD_BSEL_LSB +: 2],
                        wdata_i[CMD_INS_LSB +: 8], // see [RULE_05]
                        wdata_i[CMD_DATA_LSB +: 8]};
                    bits <= dps_cmd_bits(wdata_i[CMD_OP_LSB +: 4]);
                    mosi_q <= DEV_TYPE[3];
                    cs_n_q <= 1'b0;
                    st <= ST_SETUP;
                end
                ST_SETUP, ST_LOW: if (tick) begin
                    sck_q <= 1'b1; // see [RULE_12]
                    st <= ST_HIGH;
                end
                ST_HIGH: if (tick) begin
                    sck_q <= 1'b0;
                    rx <= {rx[6:0], miso_q[1]};
                    bits <= bits - 5'h1;
                    tx <= {tx[22:0], 1'b0};
                    mosi_q <= tx[22];
                    st <= (bits == 5'h1) ? ST_HOLD : ST_LOW;
                end
                ST_HOLD: if (tick) begin
                    cs_n_q <= 1'b1;
                    st <= ST_REST;
                end
                ST_REST: if (tick) begin
                    rx_byte <= rx;
                    ev_done <= 1'b1;
                    st <= ST_IDLE;
                end
            endcase
        end
    end

    assign spi.cs_n = cs_n_q;
    assign spi.sck = sck_q;
    assign spi.mosi = mosi_q;
endmodule : dps_pot_host

// ---- tb/dps_link_sva.sv ----
// assertions on the serial link between the two ends
`timescale 1ns/10ps
module dps_link_sva (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic sck_q;
    logic [5:0] rises;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_q <= 1'h0;
        end else begin
            sck_q <= sck;
        end
    end
    // counts rises per frame, cleared while deselected
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rises <= 6'h00;
        end else if (cs_n) begin
            rises <= 6'h00;
        end else if (sck && !sck_q) begin
            rises <= rises + 6'h01;
        end
    end
    sequence low8;
        !sck [*8];
    endsequence
    sequence high8;
        sck [*8];
    endsequence
    idle_clock_a: assert property (cs_n |-> !sck)
        else $error("clock moved while deselected");
    first_edge_a: assert property
        ($fell(cs_n) |-> low8 ##1 sck)
        else $error("bad select to first rise");
    sck_high_a: assert property
        ($rose(sck) |-> high8 ##1 !sck)
        else $error("clock high time wrong");
    sck_low_a: assert property
        ($fell(sck) && !cs_n |-> low8)
        else $error("clock low time short");
    mosi_hold_a: assert property
        (sck && $past(sck) |-> $stable(mosi))
        else $error("data in moved while clock high");
    miso_hold_a: assert property
        (miso_oe && sck && $past(sck) |-> $stable(miso))
        else $error("data out moved while clock high");
    oe_idle_a: assert property
        (cs_n && $past(cs_n, 8) |-> !miso_oe)
        else $error("output driven while idle");
    frame_len_a: assert property
        ($rose(cs_n) |-> rises == 6'h10 || rises == 6'h18)
        else $error("frame length not 16 or 24");
endmodule : dps_link_sva

// ---- tb/testbench.sv ----
// testbench joining host and device ends over the serial link
`timescale 1ns/10ps
module testbench;
    import dps_pkg::*;
    localparam int NV_SIM = 2000;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [1:0] board = 2'h2;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, pend;
    logic [1:0] bresp, rresp, b, rs;
    logic [31:0] rdata, r;
    logic [POTS-1:0][7:0] tap;
    int mismatches = 0;
    int comparisons = 0;
    dps_spi_if spi_bus();
    always #10 clk = ~clk;
    dps_pot_dev #(.NV_CYC(NV_SIM)) dps_pot_dev_inst (.sys_clk_i(clk),
        .nrst_i(nrst), .board_select_bits_i(board), .spi(spi_bus),
        .wiper_tap_o(tap), .nv_write_pending_o(pend));
    // short power-up wait keeps the run brief
    dps_pot_host #(.PU_CYC(40)) dps_pot_host_inst (.sys_clk_i(clk),
        .nrst_i(nrst), .awaddr_i(awaddr), .awvalid_i(awvalid),
        .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf),
        .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
        .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr),
        .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
        .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
        .irq_o(irq), .spi(spi_bus));
    dps_link_sva dps_link_sva_inst (.sys_clk_i(clk), .nrst_i(nrst),
        .cs_n(spi_bus.cs_n), .sck(spi_bus.sck), .mosi(spi_bus.mosi),
        .miso(spi_bus.miso), .miso_oe(spi_bus.miso_oe));
    task stop_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do @(posedge clk); while (awready !== 1'h1);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        while (bvalid !== 1'h1) @(posedge clk);
        bready <= 1'h0;
        s = bresp;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge clk);
        rready <= 1'h0;
        d = rdata;
        s = rresp;
    endtask : rd
    // one frame, then poll until idle; r holds the final status word
    task cmd(input logic [1:0] bs, input logic [3:0] op,
        input logic [1:0] sl, input logic [1:0] wi, input logic [7:0] d);
        wr(REG_CMD, {14'h0, bs, op, sl, wi, d}, b);
        do rd(REG_STATUS, r, rs); while (r[STAT_BUSY_BIT] !== 1'h0);
    endtask : cmd
    task settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle
    task t_powerup;
        wr(REG_CMD, 32'h2a13c, b);
        rd(REG_IRQ_STAT, r, rs);
        chk(r[EV_REFUSED_BIT], 1'h1);
        rd(REG_IRQ_EN, r, rs);
        chk(r, 32'h0);
        chk(rs, RESP_OKAY);
        settle(WIPER_SETTLE_CYC + 20);
        rd(REG_STATUS, r, rs);
        chk(r[STAT_PURDY_BIT], 1'h1);
        chk(tap, 16'h8080);
    endtask : t_powerup
    task t_irq;
        wr(REG_IRQ_EN, 32'h2, b);
        chk(b, RESP_OKAY);
        settle(3);
        chk(irq, 1'h1);
        wr(REG_IRQ_CLR, 32'h2, b);
        settle(3);
        chk(irq, 1'h0);
        wr(REG_IRQ_EN, 32'h1, b);
    endtask : t_irq
    task t_wiper;
        cmd(2'h2, OP_WR_WPOS, 2'h0, 2'h1, 8'h3c);
        settle(WIPER_LAT_CYC);
        chk(irq, 1'h1);
        chk(tap, 16'h3c80);
        cmd(2'h2, OP_RD_WPOS, 2'h0, 2'h1, 8'h00);
        chk(r[15:8], 8'h3c);
        rd(REG_CMD, r, rs);
        chk(r, 32'h29100);
        wr(REG_IRQ_CLR, 32'h1, b);
    endtask : t_wiper
    task t_select;
        cmd(2'h1, OP_WR_WPOS, 2'h0, 2'h0, 8'h11);
        settle(WIPER_LAT_CYC + 20);
        chk(tap, 16'h3c80);
        board <= 2'h1;
        cmd(2'h1, OP_WR_WPOS, 2'h0, 2'h0, 8'h22);
        settle(WIPER_LAT_CYC);
        chk(tap, 16'h3c22);
    endtask : t_select
    task t_setting;
        cmd(2'h1, OP_WR_SET, 2'h1, 2'h0, 8'h5a);
        chk(pend, 1'h1);
        cmd(2'h1, OP_RD_STATUS, 2'h0, 2'h0, 8'h00);
        chk(r[8], 1'h1);
        settle(NV_SIM);
        chk(pend, 1'h0);
        cmd(2'h1, OP_RD_SET, 2'h1, 2'h0, 8'h00);
        chk(r[15:8], 8'h5a);
        cmd(2'h1, OP_RD_SET, 2'h0, 2'h0, 8'h00);
        chk(r[15:8], 8'h80);
        // two-byte transfer: slot one of pot zero into its wiper
        cmd(2'h1, OP_SET_TO_WPOS, 2'h1, 2'h0, 8'h00);
        settle(WIPER_LAT_CYC);
        chk(tap, 16'h3c5a);
    endtask : t_setting
    task t_unmapped;
        rd(8'h20, r, rs);
        chk(rs, RESP_DECERR);
        chk(r, 32'h0);
        wr(8'h24, 32'h1, b);
        chk(b, RESP_DECERR);
    endtask : t_unmapped
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        t_powerup;
        t_irq;
        t_wiper;
        t_select;
        t_setting;
        t_unmapped;
        stop_test;
    end
    initial begin
        #1000000;
        mismatches++;
        stop_test;
    end
endmodule : testbench
